// ---- core/pira_pkg.sv ----
// constants, bit positions and helper functions of the periodic interrupt
// and pulse accumulator block; assumes one 200 MHz pclk acting as the E clock.
package pira_pkg;

	// ==========================================================
	// register map, byte addresses on the apb bus
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  OFF_ENABLE  = 8'h00;  // timer_event_enable_2
	localparam logic [7:0]  OFF_FLAGS   = 8'h04;  // timer_event_flags_2
	localparam logic [7:0]  OFF_CONTROL = 8'h08;  // accumulator_control
	localparam logic [7:0]  OFF_COUNT   = 8'h0c;  // accumulator_count
	localparam logic [7:0]  OFF_MAIN    = 8'h10;  // main_free_running_counter

	// ==========================================================
	// field positions; flag and enable bits share positions
	localparam int unsigned BIT_WRAP     = 7;
	localparam int unsigned BIT_PERIODIC = 6;
	localparam int unsigned BIT_OVF      = 5;
	localparam int unsigned BIT_EDGE     = 4;
	localparam int unsigned CTL_A7_DIR   = 7;
	localparam int unsigned CTL_ENABLE   = 6;
	localparam int unsigned CTL_MODE     = 5;
	localparam int unsigned CTL_EDGE     = 4;
	localparam int unsigned CTL_A3_DIR   = 3;
	localparam int unsigned CTL_CC_SEL   = 2;
	localparam logic [7:0]  FLAG_MASK    = 8'hf0;  // implemented flag/enable bits
	localparam logic [7:0]  ENABLE_MASK  = 8'hf3;  // enable reg: 3:2 unimplemented

	// ==========================================================
	// reset values
	localparam logic [7:0]  ENABLE_RESET  = 8'h00;
	localparam logic [7:0]  FLAGS_RESET   = 8'h00;
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [15:0] MAIN_RESET    = 16'h0000;

	// ==========================================================
	// cycle counts
	localparam int unsigned CHAIN_W        = 16;  // divider chain width
	localparam int unsigned PERIODIC_SHIFT = 13;  // base periodic division 2^13
	localparam int unsigned GATED_SHIFT    = 6;   // gated clock E/64
	localparam logic [6:0]  PR_WINDOW      = 7'h40;  // 64 cycles for prescaler write

	// true when the low n bits of v are all ones (n = 0 always true)
	function automatic logic low_ones(input logic [15:0] v, input int unsigned n);
		logic r;
		r = 1'b1;
		for (int unsigned i = 0; i < 16; i++) begin
			if (i < n && !v[i]) begin
				r = 1'b0;
			end
		end
		return r;
	endfunction

	// prescaler code to shift: divide by 1, 4, 8, 16
	function automatic int unsigned prescale_shift(input logic [1:0] code);
		int unsigned s;
		s = 0;
		case (code)
			2'h0: s = 0;
			2'h1: s = 2;
			2'h2: s = 3;
			2'h3: s = 4;
			default: s = 0;
		endcase
		return s;
	endfunction

endpackage

// ---- core/pira_sync2.sv ----
// two-stage synchroniser for the accumulator input pin
// assumes the pin is asynchronous to pclk
module pira_sync2
	import pira_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic async_in,
	output logic      sync_out
);

	logic meta;  // first stage, read only by the second

	// ==========================================================
	// two flops; first stage feeds nothing but the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta     <= 1'b0;
			sync_out <= 1'b0;
		end else if (ce) begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// ---- core/pira_chain.sv ----
// free-running divider chain of the E clock; stops during reset and while ce is low
// taps for the periodic, prescaler and E/64 ticks are decoded by the user
module pira_chain
	import pira_pkg::*;
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               ce,
	output logic      [CHAIN_W-1:0] chain
);

	// ==========================================================
	// plain binary count, wraps naturally
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain <= '0;
		end else if (ce) begin
			chain <= chain + 16'h0001;
		end
	end

endmodule

// ---- core/pira_top.sv ----
// periodic interrupt generator, main counter wrap flag and 8-bit pulse
// accumulator with apb register access; pclk is the E clock, ce freezes all.
module pira_top
	import pira_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              accumulator_input_pin,
	output logic                   irq_request,
	output logic                   capture4_compare5_select,
	output logic                   port_a7_direction,
	output logic                   port_a3_direction
);

	// ==========================================================
	// state
	logic [CHAIN_W-1:0] chain;                // free-running E divider
	logic [7:0]         timer_event_enable_2; // enables 7:4, prescaler 1:0
	logic [7:0]         timer_event_flags_2;  // flags 7:4
	logic [7:0]         accumulator_control;  // control byte
	logic [7:0]         accumulator_count;    // no reset on purpose
	logic [15:0]        main_free_running_counter;
	logic [6:0]         since_reset;          // cycles since reset, saturates
	logic               pr_written;           // prescaler already written once
	logic               pin_sync;             // synchronised input pin
	logic               pin_prev;             // previous synchronised level
	logic               pin_prev_valid;       // blocks a false edge after reset

	// ==========================================================
	// decoded controls and events
	logic       wr_access;      // write taking effect this edge
	logic       wr_enable;
	logic       wr_flags;
	logic       wr_control;
	logic       wr_count;
	logic       rti_timeout;
	logic       prescale_tick;
	logic       gated_tick;
	logic       main_wrap;
	logic       rise;
	logic       fall;
	logic       sel_edge;
	logic       gate_active;
	logic       acc_inc;
	logic       acc_ovf;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic       acc_enable;
	logic       acc_mode;
	logic       acc_edge;
	logic [1:0] periodic_rate_select;
	logic [1:0] counter_divider_select;

	assign acc_enable             = accumulator_control[CTL_ENABLE];
	assign acc_mode               = accumulator_control[CTL_MODE];
	assign acc_edge               = accumulator_control[CTL_EDGE];
	assign periodic_rate_select   = accumulator_control[1:0];
	assign counter_divider_select = timer_event_enable_2[1:0];

	// ==========================================================
	// leaf instances
	pira_chain u_chain (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.chain   (chain)
	);

	// pin crosses into pclk before any edge or gate logic looks at it
	pira_sync2 u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.async_in (accumulator_input_pin),
		.sync_out (pin_sync)
	);

	// ==========================================================
	// chain taps: periodic tick ignores the prescaler setting
	// chain starts at zero, so the first timeout ends a full interval
	assign rti_timeout   = low_ones(chain, PERIODIC_SHIFT + 32'(periodic_rate_select));
	assign prescale_tick = low_ones(chain, prescale_shift(counter_divider_select));
	assign gated_tick    = low_ones(chain, GATED_SHIFT);
	assign main_wrap     = prescale_tick && (main_free_running_counter == 16'hffff);

	// ==========================================================
	// input edge and gate decode
	assign rise        = pin_prev_valid && pin_sync && !pin_prev;
	assign fall        = pin_prev_valid && !pin_sync && pin_prev;
	assign sel_edge    = acc_edge ? rise : fall;
	assign gate_active = acc_edge ? !pin_sync : pin_sync;
	// event mode counts edges, gated mode counts E/64 while the gate is open
	assign acc_inc     = acc_enable && (acc_mode ? (gate_active && gated_tick) : sel_edge);
	assign acc_ovf     = acc_inc && !wr_count && (accumulator_count == 8'hff);

	// ==========================================================
	// apb write decode: effect only on the sampled access edge
	assign wr_access  = psel && penable && pready && pwrite && !pslverr;
	assign wr_enable  = wr_access && (paddr == OFF_ENABLE);
	assign wr_flags   = wr_access && (paddr == OFF_FLAGS);
	assign wr_control = wr_access && (paddr == OFF_CONTROL);
	assign wr_count   = wr_access && (paddr == OFF_COUNT);

	// ==========================================================
	// flag set and clear vectors
	always_comb begin
		flag_set               = 8'h00;
		flag_set[BIT_WRAP]     = main_wrap;
		flag_set[BIT_PERIODIC] = rti_timeout;
		flag_set[BIT_OVF]      = acc_ovf;
		flag_set[BIT_EDGE]     = acc_enable && sel_edge;
		// only ones clear; zeros leave flags alone
		flag_clr = wr_flags ? (pwdata[7:0] & FLAG_MASK) : 8'h00;
	end

	// ==========================================================
	// flags: set beats clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_event_flags_2 <= FLAGS_RESET;
		end else if (ce) begin
			timer_event_flags_2 <= ((timer_event_flags_2 & ~flag_clr) | flag_set) & FLAG_MASK;
		end
	end

	// ==========================================================
	// enable register; prescaler field writable once in the first 64 cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_event_enable_2 <= ENABLE_RESET;
			pr_written           <= 1'b0;
		end else if (ce && wr_enable) begin
			timer_event_enable_2[7:4] <= pwdata[7:4];
			if (!pr_written && since_reset < PR_WINDOW) begin
				timer_event_enable_2[1:0] <= pwdata[1:0];
				pr_written                <= 1'b1;
			end
		end
	end

	// cycles since reset, saturating past the prescaler window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_reset <= 7'h00;
		end else if (ce && since_reset < PR_WINDOW) begin
			since_reset <= since_reset + 7'h01;
		end
	end

	// ==========================================================
	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accumulator_control <= CONTROL_RESET;
		end else if (ce && wr_control) begin
			accumulator_control <= pwdata[7:0];
		end
	end

	// ==========================================================
	// accumulator count: no reset, software write wins over an increment
	// all updates happen on the edge, a read samples the settled value
	always_ff @(posedge pclk) begin
		if (ce) begin
			if (wr_count) begin
				accumulator_count <= pwdata[7:0];
			end else if (acc_inc) begin
				accumulator_count <= accumulator_count + 8'h01;
			end
		end
	end

	// ==========================================================
	// main counter, advances on each prescaler tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_free_running_counter <= MAIN_RESET;
		end else if (ce && prescale_tick) begin
			main_free_running_counter <= main_free_running_counter + 16'h0001;
		end
	end

	// ==========================================================
	// edge detector history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev       <= 1'b0;
			pin_prev_valid <= 1'b0;
		end else if (ce) begin
			pin_prev       <= pin_sync;
			pin_prev_valid <= 1'b1;
		end
	end

	// ==========================================================
	// interrupt request: any flag with its enable, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_request <= 1'b0;
		end else if (ce) begin
			irq_request <= |(timer_event_flags_2 & timer_event_enable_2 & FLAG_MASK);
		end
	end

	// control bits driven out from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture4_compare5_select <= 1'b0;
			port_a7_direction        <= 1'b0;
			port_a3_direction        <= 1'b0;
		end else if (ce) begin
			capture4_compare5_select <= accumulator_control[CTL_CC_SEL];
			port_a7_direction        <= accumulator_control[CTL_A7_DIR];
			port_a3_direction        <= accumulator_control[CTL_A3_DIR];
		end
	end

	// ==========================================================
	// apb slave: one wait-free access phase, data captured at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				// read mux; unimplemented bits come back as zero
				case (paddr)
					OFF_ENABLE:  prdata <= {24'h0, timer_event_enable_2 & ENABLE_MASK};
					OFF_FLAGS:   prdata <= {24'h0, timer_event_flags_2 & FLAG_MASK};
					OFF_CONTROL: prdata <= {24'h0, accumulator_control};
					OFF_COUNT:   prdata <= {24'h0, accumulator_count};
					OFF_MAIN:    prdata <= {16'h0, main_free_running_counter};
					default: begin
						prdata  <= 32'h0000_0000;
						pslverr <= 1'b1;  // unmapped address
					end
				endcase
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [15:0] age;  // cycles of ce since reset, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age <= 16'h0000;
		end else if (ce && age != 16'hffff) begin
			age <= age + 16'h0001;
		end
	end

	// count has no reset, so it stays unknown until first written;
	// acc_disabled_a waits for that, gated_idle_a does not; this flag has no reset either
	logic count_loaded;
	always_ff @(posedge pclk) begin
		if (ce) begin
			count_loaded <= count_loaded | wr_count;
		end
	end

	periodic_set_a: assert property (ce && rti_timeout |=> timer_event_flags_2[BIT_PERIODIC])
		else $error("periodic timeout did not set flag");
	first_interval_a: assert property (timer_event_flags_2[BIT_PERIODIC] |-> age >= 16'h2000)
		else $error("periodic flag set before first full interval");
	periodic_clear_a: assert property (ce && wr_flags && pwdata[BIT_PERIODIC] && !rti_timeout
		|=> !timer_event_flags_2[BIT_PERIODIC])
		else $error("periodic flag not cleared");
	flag_hold_a: assert property (ce && timer_event_flags_2[BIT_OVF] && !(wr_flags && pwdata[BIT_OVF])
		|=> timer_event_flags_2[BIT_OVF])
		else $error("overflow flag lost without clear");
	irq_gate_a: assert property (ce && |(timer_event_flags_2 & timer_event_enable_2 & FLAG_MASK)
		|=> irq_request)
		else $error("enabled flag gave no request");
	wrap_flag_a: assert property (ce && prescale_tick && main_free_running_counter == 16'hffff
		|=> main_free_running_counter == 16'h0000 && timer_event_flags_2[BIT_WRAP])
		else $error("main counter wrap not flagged");
	ovf_flag_a: assert property (ce && acc_inc && !wr_count && accumulator_count == 8'hff
		|=> accumulator_count == 8'h00 && timer_event_flags_2[BIT_OVF])
		else $error("accumulator rollover not flagged");
	acc_disabled_a: assert property (ce && count_loaded && !acc_enable && !wr_count
		|=> $stable(accumulator_count))
		else $error("disabled accumulator counted");
	gated_idle_a: assert property (ce && acc_enable && acc_mode && !gated_tick && !wr_count
		|=> $stable(accumulator_count))
		else $error("gated count moved off the E/64 tick");
	unimpl_zero_a: assert property (pready && psel && (paddr == OFF_FLAGS || paddr == OFF_ENABLE)
		|-> prdata[3:2] == 2'b00 && (paddr != OFF_FLAGS || prdata[1:0] == 2'b00))
		else $error("unimplemented bits read nonzero");

endmodule

// ---- dv/pira_pin_model.sv ----
// behavioural source of the accumulator input pin; toggles it on command
// assumes the bench pulses go for one cycle together with the toggle count
module pira_pin_model
(
	input  wire logic       pclk,
	input  wire logic       go,
	input  wire logic [3:0] n_toggles,
	output logic            pin,
	output logic            busy
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// toggle sequencer
	logic [3:0] left;  // toggles still to make
	logic [1:0] gap;   // cycles since the last toggle

	initial begin
		pin = 1'b0;
		left = 4'h0;
		gap = 2'h0;
	end

	// every level is held four cycles, well below the E/2 event limit
	always @(posedge pclk) begin
		if (go) begin
			left <= n_toggles;
			gap <= 2'h0;
		end else if (left != 4'h0) begin
			gap <= gap + 2'h1;
			if (gap == 2'h3) begin
				pin <= ~pin;
				left <= left - 4'h1;
			end
		end
	end

	assign busy = (left != 4'h0);
endmodule

// ---- dv/pira_top_tb_top.sv ----
// self-checking bench of pira_top: apb tasks, periodic and accumulator scenarios
// assumes pira_pin_model drives the accumulator pin; ce drops once, in t_wrap
module pira_top_tb_top
	import pira_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// signals
	logic              pclk;
	logic              presetn;
	logic              ce;        // clock enable, low only in t_wrap
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              irq_request;
	logic [2:0]        dirs;      // a7 dir, a3 dir, capture select
	logic              go;
	logic [3:0]        n_tog;
	logic              pin;
	logic              busy;
	logic [31:0]       rd;        // last read data
	logic              err;       // last error response
	int                n_errors;
	int                checks_done;
	int                cyc;       // free cycle count for timing

	pira_top pira_top_inst (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.accumulator_input_pin(pin), .irq_request(irq_request),
		.capture4_compare5_select(dirs[0]), .port_a7_direction(dirs[2]),
		.port_a3_direction(dirs[1]));

	pira_pin_model pira_pin_model_inst (
		.pclk(pclk), .go(go), .n_toggles(n_tog), .pin(pin), .busy(busy));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	always @(posedge pclk) cyc <= cyc + 1;

	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; waits for pready, bounded
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k == 20) n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_irq(input logic lvl);
		int k;
		k = 0;
		while (irq_request !== lvl && k < 70000) begin
			@(posedge pclk);
			k++;
		end
		if (k == 70000) n_errors++;
	endtask

	// toggle the pin n times, then let sync and count settle
	task automatic tog(input logic [3:0] n);
		int k;
		@(posedge pclk);
		go <= 1'b1;
		n_tog <= n;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		k = 0;
		while (busy === 1'b1 && k < 100) begin
			@(posedge pclk);
			k++;
		end
		repeat (6) @(posedge pclk);
	endtask

	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs;
		apb(1, OFF_ENABLE, 32'hff);
		apb(0, OFF_ENABLE, 0);
		check(rd, 32'hf3);
		apb(1, OFF_ENABLE, 32'h00);
		apb(0, OFF_ENABLE, 0);
		check(rd, 32'h03);
		apb(1, OFF_FLAGS, 32'hff);
		apb(0, OFF_FLAGS, 0);
		check(rd & 32'h0f, 32'h0);
		apb(1, 8'h20, 32'h12);
		check(err, 1'b1);
		apb(1, OFF_CONTROL, 32'h8c);
		repeat (2) @(posedge pclk);
		check(dirs, 3'h7);
		apb(0, OFF_CONTROL, 0);
		check(rd, 32'h8c);
		apb(1, OFF_CONTROL, 32'h00);
		repeat (2) @(posedge pclk);
		check(dirs, 3'h0);
	endtask

	task automatic t_reset_keep;
		int t0;
		apb(1, OFF_COUNT, 32'h5a);
		do_reset();
		t0 = cyc;
		apb(1, OFF_ENABLE, 32'h40);
		wait_irq(1'b1);
		check(cyc - t0 >= 8191 && cyc - t0 <= 8195, 1'b1);
		apb(0, OFF_COUNT, 0);
		check(rd, 32'h5a);
		apb(1, OFF_FLAGS, 32'h40);
		repeat (2) @(posedge pclk);
		check(irq_request, 1'b0);
	endtask

	// the clear comes late on purpose: the period must not move
	task automatic t_periodic(input logic [1:0] r);
		int t0;
		apb(1, OFF_CONTROL, {30'h0, r});
		apb(1, OFF_ENABLE, 32'h40);
		apb(1, OFF_FLAGS, 32'h40);
		repeat (3) @(posedge pclk);
		wait_irq(1'b1);
		t0 = cyc;
		repeat (100) @(posedge pclk);
		apb(1, OFF_FLAGS, 32'h40);
		wait_irq(1'b0);
		wait_irq(1'b1);
		check(cyc - t0, 32'd8192 << r);
		apb(1, OFF_ENABLE, 32'h00);
	endtask

	task automatic t_events;
		apb(1, OFF_CONTROL, 32'h50);
		apb(1, OFF_COUNT, 32'hfe);
		apb(1, OFF_FLAGS, 32'h70);
		tog(4'd3);
		apb(0, OFF_COUNT, 0);
		check(rd, 32'h00);
		apb(0, OFF_FLAGS, 0);
		check(rd & 32'h30, 32'h30);
		apb(1, OFF_ENABLE, 32'h20);
		repeat (2) @(posedge pclk);
		check(irq_request, 1'b1);
		apb(1, OFF_FLAGS, 32'h20);
		apb(0, OFF_FLAGS, 0);
		check(rd & 32'h30, 32'h10);
		check(irq_request, 1'b0);
		apb(1, OFF_ENABLE, 32'h10);
		repeat (2) @(posedge pclk);
		check(irq_request, 1'b1);
		apb(1, OFF_FLAGS, 32'h10);
		repeat (2) @(posedge pclk);
		check(irq_request, 1'b0);
		apb(1, OFF_ENABLE, 32'h00);
		apb(1, OFF_CONTROL, 32'h40);
		tog(4'd1);
		apb(0, OFF_COUNT, 0);
		check(rd, 32'h01);
		tog(4'd1);
		apb(0, OFF_COUNT, 0);
		check(rd, 32'h01);
		apb(1, OFF_CONTROL, 32'h00);
		apb(1, OFF_FLAGS, 32'h10);
		tog(4'd2);
		apb(0, OFF_COUNT, 0);
		check(rd, 32'h01);
		apb(0, OFF_FLAGS, 0);
		check(rd & 32'h10, 32'h0);
	endtask

	task automatic t_gated;
		logic [31:0] v;
		for (int e = 0; e < 2; e++) begin
			apb(1, OFF_CONTROL, (e == 1) ? 32'h70 : 32'h60);
			if (pin !== (e == 0)) tog(4'd1);
			apb(1, OFF_COUNT, 32'h00);
			repeat (640) @(posedge pclk);
			apb(0, OFF_COUNT, 0);
			check(rd >= 10 && rd <= 11, 1'b1);
			tog(4'd1);
			apb(0, OFF_COUNT, 0);
			v = rd;
			repeat (640) @(posedge pclk);
			apb(0, OFF_COUNT, 0);
			check(rd, v);
		end
	endtask

	// main counter runs at prescaler 1 since the mid-run reset; ce low must
	// freeze it, and its wrap must raise the flag and the request
	task automatic t_wrap;
		logic [31:0] m;
		apb(0, OFF_MAIN, 0);
		m = rd;
		@(posedge pclk);
		ce <= 1'b0;
		repeat (50) @(posedge pclk);
		ce <= 1'b1;
		apb(0, OFF_MAIN, 0);
		// 54 edges between the two setups, 50 of them frozen
		check(rd, m + 32'h4);
		apb(1, OFF_FLAGS, 32'h80);
		apb(1, OFF_ENABLE, 32'h80);
		wait_irq(1'b1);
		apb(0, OFF_MAIN, 0);
		check(rd <= 32'h8, 1'b1);
		apb(0, OFF_FLAGS, 0);
		check(rd & 32'h80, 32'h80);
		apb(1, OFF_ENABLE, 32'h00);
	endtask

	// ==========================================================
	// verdict, main sequence and watchdog
	task automatic results;
		$display("checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		go = 1'b0;
		n_tog = 4'h0;
		n_errors = 0;
		checks_done = 0;
		cyc = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_reset_keep();
		t_periodic(2'h0);
		t_periodic(2'h1);
		t_events();
		t_gated();
		t_wrap();
		results();
	end

	// normal run is about 66k cycles, most of it waiting for periodic timeouts
	initial begin
		#450000;
		n_errors++;
		results();
	end
endmodule
